/* rtl/bcr_map.svh */
// Register offsets, field positions, address windows and reset values of the board control bank
`ifndef BCR_MAP_SVH
`define BCR_MAP_SVH

`define BCR_ADDR_W        10
`define BCR_DATA_W        4
`define BCR_BASE_0        10'h100
`define BCR_BASE_1        10'h110
`define BCR_BASE_2        10'h120
`define BCR_BASE_3        10'h130
`define BCR_ETH_BASE_0    10'h200
`define BCR_ETH_BASE_1    10'h240
`define BCR_ETH_BASE_2    10'h300
`define BCR_ETH_BASE_3    10'h340
`define BCR_ETH_WIN_MASK  10'h3e0
`define BCR_REG_WIN_MASK  10'h3f0
`define BCR_OFS_IDENT     4'h0
`define BCR_OFS_REVISION  4'h4
`define BCR_OFS_JUMPER    4'h8
`define BCR_OFS_POWER     4'hc
`define BCR_JMP_NARROW    0
`define BCR_JMP_IRQ5      1
`define BCR_JMP_IRQ6      2
`define BCR_JMP_IRQ7      3
`define BCR_PWR_EN_BIT    0
`define BCR_PWR_RESET     1'h0
`define BCR_RDATA_RESET   4'h0

`endif

/* rtl/bcr_pkg.sv */
// Types shared by the board control register bank
package bcr_pkg;
    typedef enum logic [1:0] {
        BCR_REG_IDENT    = 2'h0,
        BCR_REG_REVISION = 2'h1,
        BCR_REG_JUMPER   = 2'h3,
        BCR_REG_POWER    = 2'h2
    } bcr_reg_sel_type;

    typedef enum logic [1:0] {
        BCR_PWR_OFF     = 2'h0,
        BCR_PWR_ARMED   = 2'h1,
        BCR_PWR_ON      = 2'h3
    } bcr_pwr_state_type;
endpackage

/* rtl/bcr_decode.sv */
// Address decoder: jumper-selected windows for the register bank and Ethernet controller
`timescale 1ns/1ns
`default_nettype none
`include "bcr_map.svh"
module bcr_decode
    import bcr_pkg::*;
(
    input  wire logic [1:0]              jumper_in,
    input  wire logic [`BCR_ADDR_W-1:0]  addr_in,
    output logic                         reg_hit_out,
    output bcr_reg_sel_type              reg_sel_out,
    output logic                         eth_hit_out
);
    logic [`BCR_ADDR_W-1:0] reg_base;
    logic [`BCR_ADDR_W-1:0] eth_base;

    always_comb begin
        case (jumper_in)
            2'h0: begin
                reg_base = `BCR_BASE_0;
                eth_base = `BCR_ETH_BASE_0;
            end
            2'h1: begin
                reg_base = `BCR_BASE_1;
                eth_base = `BCR_ETH_BASE_1;
            end
            2'h2: begin
                reg_base = `BCR_BASE_2;
                eth_base = `BCR_ETH_BASE_2;
            end
            default: begin
                reg_base = `BCR_BASE_3;
                eth_base = `BCR_ETH_BASE_3;
            end
        endcase
    end

    // Low two address bits must be zero: only word offsets 0,4,8,c respond
    assign reg_hit_out = ((addr_in & `BCR_REG_WIN_MASK) == reg_base)
                         && (addr_in[1:0] == 2'h0);
    assign eth_hit_out = (addr_in & `BCR_ETH_WIN_MASK) == eth_base;

    always_comb begin
        case (addr_in[3:2])
            2'h0:    reg_sel_out = BCR_REG_IDENT;
            2'h1:    reg_sel_out = BCR_REG_REVISION;
            2'h2:    reg_sel_out = BCR_REG_JUMPER;
            default: reg_sel_out = BCR_REG_POWER;
        endcase
    end
endmodule
`default_nettype wire

/* rtl/bcr_top.sv */
// Board control register bank on the ISA-style stacking bus
`timescale 1ns/1ns
`default_nettype none
`include "bcr_map.svh"
module bcr_top
    import bcr_pkg::*;
#(
    parameter logic [`BCR_DATA_W-1:0] BOARD_IDENT    = 4'ha, // Arbitrary value
    parameter logic [`BCR_DATA_W-1:0] LOGIC_REVISION = 4'h1
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_in,
    input  wire logic                    clk_en_in,
    // Bus side
    input  wire logic [`BCR_ADDR_W-1:0]  addr_in,
    input  wire logic                    aen_in,
    input  wire logic                    ior_n_in,
    input  wire logic                    iow_n_in,
    input  wire logic [`BCR_DATA_W-1:0]  data_in,
    output logic      [`BCR_DATA_W-1:0]  data_out,
    output logic                         data_oe_out,
    output logic                         iocs16_n_out,
    output logic                         iocs16_n_oe_out,
    // Jumpers, 1 = installed
    input  wire logic                    base_select_jumper_low_in,
    input  wire logic                    base_select_jumper_high_in,
    input  wire logic                    irq5_jumper_in,
    input  wire logic                    irq6_jumper_in,
    input  wire logic                    irq7_jumper_in,
    input  wire logic                    narrow_bus_jumper_in,
    // Ethernet controller side
    input  wire logic                    eth_irq_in,
    output logic                         eth_cs_out,
    output logic                         irq5_out,
    output logic                         irq6_out,
    output logic                         irq7_out,
    // PoE front end
    input  wire logic                    poe_signature_ok_in,
    input  wire logic                    poe_class_ok_in,
    output logic                         bus_power_en_out,
    output logic                         power_good_lamp_out
);
    // ==========================================================
    // State
    typedef struct packed {
        logic                    iow_n;
        logic                    pwr_bit;
        bcr_pwr_state_type       pwr_st;
        logic [`BCR_DATA_W-1:0]  rdata;
        logic                    rd_oe;
    } bcr_state_type;

    bcr_state_type st_r;
    bcr_state_type st_nxt;

    logic             reg_hit;
    logic             eth_hit;
    bcr_reg_sel_type  reg_sel;
    logic             cycle_ok;
    logic             poe_valid;
    logic [3:0]       jumper_word;

    // ==========================================================
    // Address decode
    bcr_decode bcr_decode_inst (
        .jumper_in   ({base_select_jumper_high_in, base_select_jumper_low_in}),
        .addr_in     (addr_in),
        .reg_hit_out (reg_hit),
        .reg_sel_out (reg_sel),
        .eth_hit_out (eth_hit)
    );

    // DMA cycles drive AEN high and must never decode
    assign cycle_ok  = !aen_in;
    assign poe_valid = poe_signature_ok_in && poe_class_ok_in;

    always_comb begin
        jumper_word = 4'h0;
        jumper_word[`BCR_JMP_IRQ7]   = irq7_jumper_in;
        jumper_word[`BCR_JMP_IRQ6]   = irq6_jumper_in;
        jumper_word[`BCR_JMP_IRQ5]   = irq5_jumper_in;
        jumper_word[`BCR_JMP_NARROW] = narrow_bus_jumper_in;
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt       = st_r;
        st_nxt.iow_n = iow_n_in;

        if (cycle_ok && reg_hit && !ior_n_in) begin
            st_nxt.rd_oe = 1'b1;
            case (reg_sel)
                BCR_REG_IDENT:    st_nxt.rdata = BOARD_IDENT;
                BCR_REG_REVISION: st_nxt.rdata = LOGIC_REVISION;
                BCR_REG_JUMPER:   st_nxt.rdata = jumper_word;
                BCR_REG_POWER:    st_nxt.rdata = {3'h0, st_r.pwr_bit};
                default:          st_nxt.rdata = `BCR_RDATA_RESET;
            endcase
        end else begin
            st_nxt.rd_oe = 1'b0;
        end

        // Write taken once, on the falling edge of the write strobe
        if (cycle_ok && reg_hit && !iow_n_in && st_r.iow_n
            && reg_sel == BCR_REG_POWER) begin
            st_nxt.pwr_bit = data_in[`BCR_PWR_EN_BIT];
        end

        // Rail needs software request and a fully valid PoE handshake
        case (st_r.pwr_st)
            BCR_PWR_OFF: begin
                if (poe_valid) begin
                    st_nxt.pwr_st = BCR_PWR_ARMED;
                end
            end
            BCR_PWR_ARMED: begin
                if (!poe_valid) begin
                    st_nxt.pwr_st = BCR_PWR_OFF;
                end else if (st_r.pwr_bit) begin
                    st_nxt.pwr_st = BCR_PWR_ON;
                end
            end
            BCR_PWR_ON: begin
                if (!poe_valid) begin
                    st_nxt.pwr_st = BCR_PWR_OFF;
                end else if (!st_r.pwr_bit) begin
                    st_nxt.pwr_st = BCR_PWR_ARMED;
                end
            end
            default: st_nxt.pwr_st = BCR_PWR_OFF;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st_r.iow_n   <= 1'b1;
            st_r.pwr_bit <= `BCR_PWR_RESET;
            st_r.pwr_st  <= BCR_PWR_OFF;
            st_r.rdata   <= `BCR_RDATA_RESET;
            st_r.rd_oe   <= 1'b0;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign data_out    = st_r.rdata;
    assign data_oe_out = st_r.rd_oe;

    // Narrow-bus mode: claim 16-bit cycles for the controller window
    assign iocs16_n_out    = 1'b0;
    assign iocs16_n_oe_out = narrow_bus_jumper_in && eth_hit && cycle_ok;
    assign eth_cs_out      = eth_hit && cycle_ok;

    // Two jumpers installed would short lines together; each gated alone
    assign irq5_out = eth_irq_in && irq5_jumper_in;
    assign irq6_out = eth_irq_in && irq6_jumper_in;
    assign irq7_out = eth_irq_in && irq7_jumper_in;

    assign bus_power_en_out    = st_r.pwr_st == BCR_PWR_ON;
    assign power_good_lamp_out = poe_valid;
endmodule
`default_nettype wire

/* testbench/bcr_top_chk.sv */
// Concurrent checks on the board control register bank ports
`timescale 1ns/1ns
`default_nettype none
module bcr_top_chk #(
    parameter logic [3:0] BOARD_IDENT    = 4'ha,
    parameter logic [3:0] LOGIC_REVISION = 4'h1
) (
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    input wire logic       aen_in,
    input wire logic       ior_n_in,
    input wire logic [9:0] addr_in,
    input wire logic [3:0] data_out,
    input wire logic       data_oe_out,
    input wire logic       iocs16_n_oe_out,
    input wire logic       eth_cs_out,
    input wire logic       base_select_jumper_low_in,
    input wire logic       base_select_jumper_high_in,
    input wire logic       irq5_jumper_in,
    input wire logic       irq6_jumper_in,
    input wire logic       irq7_jumper_in,
    input wire logic       narrow_bus_jumper_in,
    input wire logic       eth_irq_in,
    input wire logic       irq5_out,
    input wire logic       irq6_out,
    input wire logic       irq7_out,
    input wire logic       poe_signature_ok_in,
    input wire logic       poe_class_ok_in,
    input wire logic       bus_power_en_out,
    input wire logic       power_good_lamp_out
);
    // ==========
    // Window bases follow the jumpers live
    logic [9:0] base, ebase;
    logic       rd;
    assign base  = {4'h4, base_select_jumper_high_in, base_select_jumper_low_in, 4'h0};
    assign ebase = {1'b1, base_select_jumper_high_in, 1'b0, base_select_jumper_low_in, 6'h0};
    assign rd    = !aen_in && !ior_n_in;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    AST_ID: assert property (rd && addr_in == base |=> data_oe_out && data_out == BOARD_IDENT)
        else $error("board ident read wrong");
    AST_REV: assert property (rd && addr_in == base + 10'h4 |=> data_out == LOGIC_REVISION)
        else $error("revision read wrong");
    AST_JMP: assert property (rd && addr_in == base + 10'h8 |=>
        data_out == {irq7_jumper_in, irq6_jumper_in, irq5_jumper_in, narrow_bus_jumper_in})
        else $error("jumper status read wrong");
    AST_RSVD: assert property (rd && addr_in == base + 10'hc |=> data_out[3:1] == 3'h0)
        else $error("reserved power bits not zero");
    AST_MISS: assert property (!rd || addr_in[9:4] != base[9:4] |=> !data_oe_out)
        else $error("bus driven outside window");
    AST_ETH: assert property (!aen_in && (addr_in & 10'h3e0) == ebase |-> eth_cs_out)
        else $error("controller window not selected");
    AST_NARROW: assert property (iocs16_n_oe_out == (narrow_bus_jumper_in && !aen_in
        && (addr_in & 10'h3e0) == ebase))
        else $error("16-bit claim wrong");
    AST_IRQ: assert property ({irq7_out, irq6_out, irq5_out} ==
        ({irq7_jumper_in, irq6_jumper_in, irq5_jumper_in} & {3{eth_irq_in}}))
        else $error("interrupt routing wrong");
    AST_LAMP: assert property (power_good_lamp_out == (poe_signature_ok_in && poe_class_ok_in))
        else $error("power good lamp wrong");
    AST_RAIL: assert property (bus_power_en_out |-> $past(poe_signature_ok_in && poe_class_ok_in))
        else $error("rail on without valid source");
    cover property (rd && addr_in == base);
    cover property ($rose(bus_power_en_out));
    cover property (eth_cs_out && eth_irq_in);
endmodule
bind bcr_top bcr_top_chk #(.BOARD_IDENT(BOARD_IDENT), .LOGIC_REVISION(LOGIC_REVISION))
    chk_inst (.*);
`default_nettype wire

/* testbench/bcr_host_model.sv */
// Bus host model issuing single I/O cycles
`timescale 1ns/1ns
`default_nettype none
module bcr_host_model (
    input  wire logic       clk_in,
    input  wire logic [3:0] data_in,
    input  wire logic       oe_in,
    output logic      [9:0] addr_out  = 10'h000,
    output logic            aen_out   = 1'b0,
    output logic            ior_n_out = 1'b1,
    output logic            iow_n_out = 1'b1,
    output logic      [3:0] data_out  = 4'h0
);
    // ==========
    // Strobe held two edges, answer taken at the second; write data inverted once released
    task automatic cyc(input logic [9:0] a, input logic w, e, input logic [3:0] d,
                       output logic [3:0] q, output logic o);
        @(posedge clk_in);
        addr_out  <= a;
        aen_out   <= e;
        data_out  <= d;
        ior_n_out <= w;
        iow_n_out <= !w;
        repeat (2) @(posedge clk_in);
        q = data_in;
        o = oe_in;
        ior_n_out <= 1'b1;
        iow_n_out <= 1'b1;
        aen_out   <= 1'b0;
        data_out  <= ~d;
        @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

/* testbench/tb_board_control_regs.sv */
// Self-checking bench for the board control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_board_control_regs;
    // ==========
    localparam logic [3:0] ID  = 4'h6; // Arbitrary value
    localparam logic [3:0] REV = 4'h3;
    logic       clk = 0, rst = 1, jl = 0, jh = 0, j5 = 0, j6 = 0, j7 = 0, jn = 0;
    logic       eirq = 0, sig = 0, cls = 0, aen, rn, wn, oe, cs, i5, i6, i7, pen, lamp, o;
    logic       en = 1, cs16, cs16e;
    logic [9:0] a;
    logic [3:0] wd, rd, q;
    int         num_errors = 0, n_tests = 0;
    always #5 clk = ~clk;
    bcr_top #(.BOARD_IDENT(ID), .LOGIC_REVISION(REV)) bcr_top_inst (.ref_clk_in(clk),
        .rst_in(rst), .clk_en_in(en), .addr_in(a), .aen_in(aen), .ior_n_in(rn),
        .iow_n_in(wn), .data_in(wd), .data_out(rd), .data_oe_out(oe), .iocs16_n_out(cs16),
        .iocs16_n_oe_out(cs16e), .base_select_jumper_low_in(jl), .base_select_jumper_high_in(jh),
        .irq5_jumper_in(j5), .irq6_jumper_in(j6), .irq7_jumper_in(j7),
        .narrow_bus_jumper_in(jn), .eth_irq_in(eirq), .eth_cs_out(cs), .irq5_out(i5),
        .irq6_out(i6), .irq7_out(i7), .poe_signature_ok_in(sig), .poe_class_ok_in(cls),
        .bus_power_en_out(pen), .power_good_lamp_out(lamp));
    bcr_host_model host_inst (.clk_in(clk), .data_in(rd), .oe_in(oe), .addr_out(a),
        .aen_out(aen), .ior_n_out(rn), .iow_n_out(wn), .data_out(wd));
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_bases;
        for (int j = 0; j < 4; j++) begin
            @(posedge clk);
            {jh, jl} <= j[1:0];
            host_inst.cyc(10'h100 + 10'(j * 16), 0, 0, 4'h0, q, o);
            chk(q, ID);
            host_inst.cyc(10'h104 + 10'(j * 16), 0, 0, 4'h0, q, o);
            chk(q, REV);
            host_inst.cyc(10'h108 + 10'(j * 16), 0, 1, 4'h0, q, o);
            chk(o, 1'b0);
            host_inst.cyc(10'h200 + {j[1], 1'b0, j[0], 6'h0}, 0, 0, 4'h0, q, o);
            chk({cs, o, cs16e}, 3'b100);
        end
        host_inst.cyc(10'h140, 0, 0, 4'h0, q, o);
        chk(o, 1'b0);
    endtask
    task automatic t_jumpers;
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            {jh, jl} <= 2'b00;
            {j7, j6, j5, jn} <= k[3:0];
            eirq <= k[0] | k[1];
            host_inst.cyc(10'h108, 0, 0, 4'h0, q, o);
            chk(q, k[3:0]);
            chk({i7, i6, i5}, k[3:1] & {3{k[0] | k[1]}});
        end
    endtask
    task automatic t_power;
        @(posedge clk);
        {sig, cls} <= 2'b11;
        host_inst.cyc(10'h10c, 1, 0, 4'hf, q, o);
        host_inst.cyc(10'h10c, 0, 0, 4'h0, q, o);
        chk({q, pen, lamp}, 6'h07);
        cls <= 1'b0;
        repeat (2) @(posedge clk);
        chk({pen, lamp}, 2'b00);
        cls <= 1'b1;
        host_inst.cyc(10'h104, 1, 0, 4'h0, q, o);
        host_inst.cyc(10'h104, 0, 0, 4'h0, q, o);
        chk(q, REV);
        host_inst.cyc(10'h10c, 1, 0, 4'h0, q, o);
        host_inst.cyc(10'h10c, 0, 0, 4'h0, q, o);
        chk({q, pen}, 5'h00);
    endtask
    // Narrow-bus claim, frozen write, mid-run reset
    task automatic t_enable_reset;
        host_inst.cyc(10'h200, 0, 0, 4'h0, q, o);
        chk({cs16e, cs16, o}, 3'b100);
        @(posedge clk);
        en <= 1'b0;
        host_inst.cyc(10'h10c, 1, 0, 4'h1, q, o);
        @(posedge clk);
        en <= 1'b1;
        host_inst.cyc(10'h10c, 0, 0, 4'h0, q, o);
        chk({q, pen}, 5'h00);
        host_inst.cyc(10'h10c, 1, 0, 4'h1, q, o);
        chk(pen, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk({pen, oe, rd}, 6'h00);
        host_inst.cyc(10'h10c, 0, 0, 4'h0, q, o);
        chk({q, pen, o}, 6'h01);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_bases;
        t_jumpers;
        t_power;
        t_enable_reset;
        final_report;
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        final_report;
    end
endmodule
`default_nettype wire
